// *** ohs_pkg.sv ***
package ohs_pkg;
  // ===========================================================================
  // Register map (byte addresses on the bus).
  localparam logic [7:0] OHS_STEP_OFS = 8'h00;
  localparam logic [7:0] OHS_LEN_OFS = 8'h04;
  localparam logic [7:0] OHS_CTRL_OFS = 8'h08;
  localparam logic [7:0] OHS_CMD_OFS = 8'h0c;
  localparam logic [7:0] OHS_SEQ_OFS = 8'h40;
  // ===========================================================================
  // Control word field positions.
  localparam int OHS_CTRL_EN_BIT = 15;
  localparam int OHS_CTRL_PF_BIT = 14;
  // Command register field positions.
  localparam int OHS_CMD_STRB_BIT = 0;
  localparam int OHS_CMD_EN_BIT = 1;
  localparam int OHS_CMD_RST_BIT = 2;
  localparam int OHS_CMD_DIR_BIT = 3;
  localparam int OHS_CMD_NVLD_BIT = 4;
  localparam int OHS_CMD_ATT_BIT = 5;
  localparam int OHS_CMD_N_LSB = 16;
  // ===========================================================================
  // Reset values and limits.
  localparam logic [15:0] OHS_STEP_RST = 16'h0001;
  localparam logic [15:0] OHS_DEF_START = 16'h0001;
  localparam int OHS_MAX_LEN = 256;
  localparam int OHS_WORD_W = 16;
endpackage

// *** ohs_one_hot_stepper.sv ***
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - Restart forces a reset regardless of enable.
// - Reset loads start value, default one.
// - Reset clears string, sets current step bit.
// - Start value clamped into one..length.
// - Advance only on enable rising, no restart.
// - Advance clears old bit, sets new bit.
// - Direction high increments, low decrements.
// - Increment past length wraps to one.
// - Decrement below one wraps to length.
// - Detached string: step moves, bits untouched.
// - Power-flow output follows enable each scan.
// - Length is constant, one to 256.
// - State kept in step, length, control words.
// - Control word keeps last enable, power flow.
// - Control bits 0 to 13 have no function.
// - Bits beyond length in storage untouched.
// - Steps and start value count from one.
// - Step one is LSB of first word.
module ohs_one_hot_stepper
  import ohs_pkg::*;
#(
  parameter int SEQ_LEN = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic power_flow_o,
  output logic [SEQ_LEN-1:0] seq_bits_o
);

  localparam int NWORDS = (SEQ_LEN + OHS_WORD_W - 1) / OHS_WORD_W;
  localparam logic [15:0] LEN16 = 16'(SEQ_LEN);

  // ===========================================================================
  // Elaboration check.
  if (SEQ_LEN < 1 || SEQ_LEN > OHS_MAX_LEN) begin : g_len_chk
    $error("SEQ_LEN must lie between 1 and 256");
  end

  // ===========================================================================
  // Helpers.
  function automatic logic [15:0] clamp_start(input logic [15:0] n);
    // The start value is a signed integer, so a negative value clamps to one, not to length.
    if ($signed(n) < 16'sh0001) begin
      return 16'h0001;
    end else if (n > LEN16) begin
      return LEN16;
    end
    return n;
  endfunction

  function automatic logic [15:0] next_step(input logic [15:0] s, input logic up);
    if (up) begin
      return (s >= LEN16) ? 16'h0001 : 16'(s + 16'h0001);
    end
    return (s <= 16'h0001) ? LEN16 : 16'(s - 16'h0001);
  endfunction

  // Maps a 1-based step onto a bit index; step one is the string's LSB.
  function automatic logic [SEQ_LEN-1:0] onehot(input logic [15:0] s);
    logic [SEQ_LEN-1:0] v;
    v = '0;
    for (int i = 0; i < SEQ_LEN; i++) begin
      if (s == 16'(i + 1)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction

  // ===========================================================================
  // Bus decode.
  logic bus_req;
  logic wr_cmd;
  logic scan;
  logic restart;
  logic en_in;
  logic dir_up;
  logic attached;
  logic [15:0] start_val;
  logic [15:0] step_q;
  logic en_prev_q;
  logic pf_q;
  logic [SEQ_LEN-1:0] seq_q;
  logic [31:0] rd_d;
  logic advance;
  logic [15:0] new_step;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = bus_req && wb_we_i && (wb_adr_i == OHS_CMD_OFS) && wb_sel_i[0];
  // A scan is one write to the command register with the strobe bit set.
  assign scan = wr_cmd && wb_dat_i[OHS_CMD_STRB_BIT];
  assign en_in = wb_dat_i[OHS_CMD_EN_BIT];
  assign restart = wb_dat_i[OHS_CMD_RST_BIT];
  assign dir_up = wb_dat_i[OHS_CMD_DIR_BIT];
  assign attached = wb_dat_i[OHS_CMD_ATT_BIT];
  assign start_val = wb_dat_i[OHS_CMD_NVLD_BIT] ? wb_dat_i[OHS_CMD_N_LSB +: 16] : OHS_DEF_START;
  assign advance = scan && en_in && !restart && !en_prev_q;
  assign new_step = restart ? clamp_start(start_val) : next_step(step_q, dir_up);

  // ===========================================================================
  // Step word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_q <= OHS_STEP_RST;
    end else if (scan && (restart || advance)) begin
      step_q <= new_step;
    end
  end

  // ===========================================================================
  // Control word: last enable and power flow, kept for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev_q <= 1'b0;
      pf_q <= 1'b0;
    end else if (scan) begin
      en_prev_q <= en_in;
      pf_q <= en_in;
    end
  end

  assign power_flow_o = pf_q;

  // ===========================================================================
  // Sequence string; only the SEQ_LEN bits exist, so storage past length is never touched.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= '0;
    end else if (scan && attached && restart) begin
      seq_q <= onehot(new_step);
    end else if (advance && attached) begin
      seq_q <= (seq_q & ~onehot(step_q)) | onehot(new_step);
    end
  end

  assign seq_bits_o = seq_q;

  // ===========================================================================
  // Read mux and ack. The state words are read-only to software.
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == OHS_STEP_OFS) begin
      rd_d = {16'h0000, step_q};
    end else if (wb_adr_i == OHS_LEN_OFS) begin
      rd_d = {16'h0000, LEN16};
    end else if (wb_adr_i == OHS_CTRL_OFS) begin
      rd_d[OHS_CTRL_EN_BIT] = en_prev_q;
      rd_d[OHS_CTRL_PF_BIT] = pf_q;
    end else begin
      for (int w = 0; w < NWORDS; w++) begin
        if (wb_adr_i == 8'(OHS_SEQ_OFS + 8'(4 * w))) begin
          for (int b = 0; b < OHS_WORD_W; b++) begin
            if (w * OHS_WORD_W + b < SEQ_LEN) begin
              rd_d[b] = seq_q[w*OHS_WORD_W+b];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_d : 32'h0000_0000;
    end
  end

  // ===========================================================================
  // Checks.
  chk_restart_load: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && restart |=> step_q == clamp_start($past(start_val)))
    else $error("restart did not load clamped start");
  chk_clamp_low: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && restart && start_val == 16'h0000 |=> step_q == 16'h0001)
    else $error("low start not clamped to one");
  chk_restart_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && restart && attached |=> $onehot(seq_q))
    else $error("string not one-hot after restart");
  chk_steady_en: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && !restart && en_prev_q |=> $stable(step_q))
    else $error("step moved without enable edge");
  chk_wrap_up: assert property (@(posedge clk_i) disable iff (rst_i)
    advance && dir_up && step_q == LEN16 |=> step_q == 16'h0001)
    else $error("increment did not wrap to one");
  chk_wrap_down: assert property (@(posedge clk_i) disable iff (rst_i)
    advance && !dir_up && step_q == 16'h0001 |=> step_q == LEN16)
    else $error("decrement did not wrap to length");
  chk_detached: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && !attached |=> $stable(seq_q))
    else $error("detached string changed");
  chk_power_flow: assert property (@(posedge clk_i) disable iff (rst_i)
    scan |=> power_flow_o == $past(en_in))
    else $error("power flow does not follow enable");
  chk_one_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  // ===========================================================================
  // Check helpers and step sequences. The range flag serves the checks only; a step
  // outside one..length would mean a broken restart path, since software cannot
  // write the step word.
  logic step_in_range;

  assign step_in_range = (step_q >= 16'h0001) && (step_q <= LEN16);

  sequence s_restart_scan;
    scan && restart;
  endsequence

  sequence s_rise_scan;
    scan && en_in && !restart && !en_prev_q;
  endsequence

  sequence s_up_scan;
    s_rise_scan ##0 dir_up;
  endsequence

  sequence s_down_scan;
    s_rise_scan ##0 !dir_up;
  endsequence

  // ===========================================================================
  // Restart checks.
  chk_restart_over_en: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_scan ##0 !en_in
    |=> step_q == clamp_start($past(start_val)))
    else $error("restart ignored while enable low");

  chk_default_start: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_scan ##0 !wb_dat_i[OHS_CMD_NVLD_BIT]
    |=> step_q == OHS_DEF_START)
    else $error("restart without start value did not give one");

  chk_clamp_high: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_scan ##0 (!start_val[15] && start_val > LEN16)
    |=> step_q == LEN16)
    else $error("high start not clamped to length");

  chk_clamp_neg: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_scan ##0 start_val[15]
    |=> step_q == 16'h0001)
    else $error("negative start not clamped to one");

  chk_restart_string: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_scan ##0 attached
    |=> seq_q == onehot(step_q))
    else $error("restart string bit not at new step");

  // ===========================================================================
  // Advance checks.
  chk_rise_moves: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise_scan
    |=> SEQ_LEN == 1 || step_q != $past(step_q))
    else $error("enable edge did not move the step");

  chk_enable_low: assert property (@(posedge clk_i) disable iff (rst_i)
    scan && !en_in && !restart
    |=> $stable(step_q))
    else $error("step moved with enable low");

  chk_inc_step: assert property (@(posedge clk_i) disable iff (rst_i)
    s_up_scan ##0 (step_q < LEN16)
    |=> step_q == $past(step_q) + 16'h0001)
    else $error("increment did not add one");

  chk_dec_step: assert property (@(posedge clk_i) disable iff (rst_i)
    s_down_scan ##0 (step_q > 16'h0001 && step_q <= LEN16)
    |=> step_q == $past(step_q) - 16'h0001)
    else $error("decrement did not take one");

  chk_old_bit_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise_scan ##0 (attached && SEQ_LEN > 1)
    |=> (seq_q & onehot($past(step_q))) == {SEQ_LEN{1'b0}})
    else $error("old step bit not cleared");

  chk_new_bit_set: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise_scan ##0 attached
    |=> (seq_q & onehot(step_q)) != {SEQ_LEN{1'b0}})
    else $error("new step bit not set");

  chk_detached_moves: assert property (@(posedge clk_i) disable iff (rst_i)
    s_up_scan ##0 (!attached && step_q == LEN16)
    |=> step_q == 16'h0001)
    else $error("detached step did not wrap");

  chk_string_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> $onehot0(seq_q))
    else $error("more than one string bit set");

  chk_step_range: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> step_in_range)
    else $error("step outside one to length");

  // ===========================================================================
  // Scan and control word checks.
  chk_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !scan
    |=> $stable(step_q) && $stable(seq_q))
    else $error("state changed without a scan");

  chk_scan_once: assert property (@(posedge clk_i) disable iff (rst_i)
    scan
    |=> !scan)
    else $error("one write evaluated twice");

  chk_pf_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !scan
    |=> $stable(power_flow_o))
    else $error("power flow changed without a scan");

  chk_en_record: assert property (@(posedge clk_i) disable iff (rst_i)
    scan
    |=> en_prev_q == $past(en_in))
    else $error("last enable not recorded");

  chk_ctrl_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i) == OHS_CTRL_OFS
    |-> wb_dat_o[OHS_CTRL_EN_BIT] == $past(en_prev_q) && wb_dat_o[OHS_CTRL_PF_BIT] == $past(pf_q))
    else $error("control word fields wrong");

  chk_ctrl_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i) == OHS_CTRL_OFS
    |-> wb_dat_o[13:0] == 14'h0000)
    else $error("unused control bits not zero");

  // ===========================================================================
  // Bus checks.
  chk_len_word: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i) == OHS_LEN_OFS
    |-> wb_dat_o == {16'h0000, LEN16})
    else $error("length word wrong");

  chk_step_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req && wb_we_i && wb_adr_i == OHS_STEP_OFS
    |=> $stable(step_q))
    else $error("step word took a bus write");

  chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req
    |=> wb_ack_o)
    else $error("request not answered next cycle");

  chk_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o
    |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");

  chk_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o
    |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_seq_lsb: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i) == OHS_SEQ_OFS
    |-> wb_dat_o[0] == $past(seq_q[0]))
    else $error("step one not at word lsb");
endmodule

// *** ohs_host_model.sv ***
`timescale 1ns/1ps
// ==========
// Control program model: one classic Wishbone cycle per call.
module ohs_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
    wb_adr_o = 8'hff;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic ok);
    int n;
    ok = 1'b0;
    r = 32'h0;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'h3, w};
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        r = wb_dat_i;
      end
    end
    // Released address and data lines carry the inverse, so stale values never pass as live.
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// *** bit_step_sequencer_test.sv ***
`timescale 1ns/1ps
// ==========
// Bench: a length of 5 keeps both wraps short.
module bit_step_sequencer_test;
  import ohs_pkg::*;
  localparam int LEN = 5;
  logic clk_i, rst_i, cyc, stb, we, ack, pf;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wd, rd;
  logic [LEN-1:0] bits;
  int miscompares, checks_done;
  ohs_one_hot_stepper #(.SEQ_LEN(LEN)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .power_flow_o(pf), .seq_bits_o(bits));
  ohs_host_model u_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rd), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wd));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    u_host.xfer(w, a, d, r, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask
  // Command bits: 01 strobe, 02 enable, 04 restart, 08 up, 10 start given, 20 string attached.
  task automatic scan(input logic [5:0] c, input logic [15:0] n);
    logic [31:0] r;
    bus(1'b1, OHS_CMD_OFS, {n, 10'h000, c}, r);
  endtask
  task automatic advance(input logic [5:0] c);
    scan(c & 6'h3d, 16'h0000);
    scan(c | 6'h03, 16'h0000);
  endtask
  task automatic expect_state(input logic [15:0] s, input logic [LEN-1:0] b);
    logic [31:0] r;
    bus(1'b0, OHS_STEP_OFS, 32'h0, r);
    check("step", {16'h0, s}, r);
    check("bits", 32'(b), 32'(bits));
    bus(1'b0, OHS_SEQ_OFS, 32'h0, r);
    check("seq word", 32'(b), r);
  endtask
  task automatic t_restart();
    logic [31:0] r;
    expect_state(16'h1, 5'h00);
    bus(1'b0, OHS_LEN_OFS, 32'h0, r);
    check("length", LEN, r);
    scan(6'h37, 16'h3);
    expect_state(16'h3, 5'h04);
    check("power", 32'h1, 32'(pf));
    bus(1'b0, OHS_CTRL_OFS, 32'h0, r);
    check("control", 32'hc000, r);
    scan(6'h2b, 16'h0);
    expect_state(16'h3, 5'h04);
  endtask
  task automatic t_walk();
    scan(6'h21, 16'h0);
    check("power", 32'h0, 32'(pf));
    scan(6'h2a, 16'h0);
    expect_state(16'h3, 5'h04);
    scan(6'h2b, 16'h0);
    expect_state(16'h4, 5'h08);
    advance(6'h29);
    advance(6'h29);
    expect_state(16'h1, 5'h01);
    advance(6'h21);
    expect_state(16'h5, 5'h10);
    advance(6'h09);
    expect_state(16'h1, 5'h10);
  endtask
  task automatic t_clamp();
    logic [31:0] r;
    scan(6'h35, 16'h0);
    expect_state(16'h1, 5'h01);
    scan(6'h35, 16'h9);
    expect_state(16'h5, 5'h10);
    scan(6'h25, 16'h4);
    expect_state(16'h1, 5'h01);
    bus(1'b1, OHS_STEP_OFS, 32'h2, r);
    bus(1'b0, 8'h30, 32'h0, r);
    check("unmapped", 32'h0, r);
    expect_state(16'h1, 5'h01);
    advance(6'h21);
    advance(6'h21);
    expect_state(16'h4, 5'h08);
    scan(6'h35, 16'hfffe);
    expect_state(16'h1, 5'h01);
  endtask
  initial begin
    rst_i = 1'b1;
    miscompares = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_restart();
    t_walk();
    t_clamp();
    close_out();
  end
endmodule
